/* verilog/sarsr_pkg.sv */
// package: shared constants of the serial converter readout link
// assumes: included first, no imports anywhere
package sarsr_pkg;
  // ************************************************************
  // frame layout
  // ************************************************************
  localparam int RESULT_BITS = 14;
  localparam int FRAME_CYCLES = 18;
  localparam int LEAD_ZEROS = 2;
  localparam int TRACK_EDGE = 16;
  localparam logic [4:0] EDGE_CNT_RESET = 5'h00;
  localparam logic [13:0] RESULT_RESET = 14'h0000;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS = 111;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_HIGH_NS = 20;
  localparam int CS_HIGH_CYC = (CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRACK_INTERVAL_NS = 833;
  localparam int TRACK_INTERVAL_CYC = (TRACK_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIFO_DEPTH = 8;
endpackage

/* verilog/sarsr_if.sv */
// interface: the three-wire link between converter and host
// assumes: testbench resolves the data wire from the enable
`timescale 1ns/1ps
interface sarsr_if;
  logic cs_n;
  logic sclk;
  logic dout;
  logic dout_oe_n;
  // ************************************************************
  // ends of the link
  // ************************************************************
  modport device (input cs_n, input sclk, output dout, output dout_oe_n);
  modport host (output cs_n, output sclk, input dout, input dout_oe_n);
endinterface

/* verilog/sarsr_fifo.sv */
// module: small valid/ready FIFO for result words
// assumes: one clock, DEPTH a power of two
`timescale 1ns/1ps
module sarsr_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire do_wr = i_ce && i_valid && !full;
  wire do_rd = i_ce && i_ready && !empty;
  assign o_ready = !full;
  assign o_valid = !empty;
  assign o_data = mem[rd_ptr[AW-1:0]];
  // ************************************************************
  // storage and pointers
  // ************************************************************
  // memory has no reset: contents are qualified by valid
  always_ff @(posedge i_clk)
  begin
    if (do_wr)
      mem[wr_ptr[AW-1:0]] <= i_data;
  end
  // pointers
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

/* verilog/sarsr_device.sv */
// module: converter end of the link, frames and shifts out results
// assumes: cs_n and sclk come from another domain; i_sample is the
// digitised analog input, held steady by the user side
// ************************************************************
// What this block does
// - link clock paces conversion and all bits
// - full frame spans eighteen link clock cycles
// - input captured at start, held while converting
// - track mode after sixteenth falling edge
// - host may end frame early
// - result shifted out most significant first
// - bits belong to this frame's conversion
// - result is fourteen bits wide
// - host picks duty cycle within minimums
// - host keeps link clock above minimum rate
// - two zeros, then fourteen result bits
// - data driven only while select low
// - select rising early aborts and floats output
// - select falling with clock low counts edge
// ************************************************************
`timescale 1ns/1ps
module sarsr_device #(
  parameter int RESULT_BITS = sarsr_pkg::RESULT_BITS
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  sarsr_if.device link,
  input wire logic [RESULT_BITS-1:0] i_sample,
  output logic o_tracking,
  output logic o_converting
);
  typedef enum logic [1:0] {SARSR_TRACK, SARSR_CONV} sarsr_state_e;
  sarsr_state_e state;
  logic cs_m;
  logic cs_s;
  logic cs_d;
  logic ck_m;
  logic ck_s;
  logic ck_d;
  logic [4:0] edge_cnt;
  logic [RESULT_BITS-1:0] held;
  logic dout;
  logic oe_n;
  // ************************************************************
  // synchronisers and edge finders
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_d <= 1'b1;
      ck_m <= 1'b1;
      ck_s <= 1'b1;
      ck_d <= 1'b1;
    end
    else if (i_ce)
    begin
      cs_m <= link.cs_n;
      cs_s <= cs_m;
      cs_d <= cs_s;
      ck_m <= link.sclk;
      ck_s <= ck_m;
      ck_d <= ck_s;
    end
  end
  wire cs_fall = cs_d && !cs_s;
  wire cs_rise = !cs_d && cs_s;
  wire ck_fall = ck_d && !ck_s && !cs_s;
  // a select fall with the clock already low counts as the first edge
  wire fall_evt = (cs_fall && !ck_s) || (ck_fall && !cs_fall);
  wire [4:0] next_cnt = cs_fall ? (!ck_s ? 5'h01 : sarsr_pkg::EDGE_CNT_RESET)
                                : edge_cnt + 5'h01;
  // bit index into the result: edges 3..16 carry msb..lsb
  wire [4:0] bit_pos = 5'(sarsr_pkg::TRACK_EDGE) - next_cnt;
  wire zero_slot = next_cnt <= 5'(sarsr_pkg::LEAD_ZEROS);
  wire data_slot = !zero_slot && next_cnt <= 5'(sarsr_pkg::TRACK_EDGE);
  // ************************************************************
  // frame sequencing
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state <= SARSR_TRACK;
      edge_cnt <= sarsr_pkg::EDGE_CNT_RESET;
      held <= sarsr_pkg::RESULT_RESET;
    end
    else if (i_ce)
    begin
      if (cs_rise)
      begin
        state <= SARSR_TRACK;
      end
      else if (cs_fall)
      begin
        held <= i_sample;
        state <= SARSR_CONV;
        edge_cnt <= next_cnt;
      end
      else if (fall_evt && state == SARSR_CONV)
      begin
        edge_cnt <= next_cnt;
        if (next_cnt >= 5'(sarsr_pkg::TRACK_EDGE))
          state <= SARSR_TRACK;
      end
    end
  end
  // ************************************************************
  // serial output
  // ************************************************************
  // inside a frame the output is only updated on a falling event, so it is stable at rise
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      dout <= 1'b0;
      oe_n <= 1'b1;
    end
    else if (i_ce)
    begin
      oe_n <= cs_s;
      if (cs_s)
        dout <= 1'b0;
      else if (fall_evt && (state == SARSR_CONV || cs_fall))
      begin
        case (1'b1)
          zero_slot: dout <= 1'b0;
          data_slot: dout <= held[bit_pos[3:0]];
          default: dout <= 1'b0;
        endcase
      end
    end
  end
  assign link.dout = dout;
  assign link.dout_oe_n = oe_n;
  // status flops
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_tracking <= 1'b1;
      o_converting <= 1'b0;
    end
    else if (i_ce)
    begin
      o_tracking <= (state == SARSR_TRACK);
      o_converting <= (state == SARSR_CONV);
    end
  end
endmodule

/* verilog/sarsr_host.sv */
// module: host end, makes select and link clock, collects results
// assumes: link clock derived here by a divider; results leave through a FIFO
`timescale 1ns/1ps
module sarsr_host #(
  parameter int RESULT_BITS = sarsr_pkg::RESULT_BITS,
  parameter int HALF_CYC = sarsr_pkg::SCLK_HALF_CYC,
  parameter int BITS_WANTED = sarsr_pkg::RESULT_BITS
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  sarsr_if.host link,
  input wire logic i_start,
  output logic o_busy,
  output logic o_valid,
  input wire logic i_ready,
  output logic [RESULT_BITS-1:0] o_data
);
  typedef enum logic [1:0] {SARSR_IDLE, SARSR_RUN, SARSR_GAP} sarsr_hstate_e;
  sarsr_hstate_e state;
  logic cs_n;
  logic sclk;
  logic [7:0] div;
  logic [4:0] rise_cnt;
  logic [7:0] gap;
  logic [RESULT_BITS-1:0] shift;
  logic d_m;
  logic d_s;
  logic push;
  logic f_ready;
  logic f_valid;
  logic [RESULT_BITS-1:0] f_data;
  wire half_done = (div == 8'(HALF_CYC - 1));
  // frame ends after 18 cycles, or early once enough bits are in
  wire [4:0] last_rise = 5'(sarsr_pkg::LEAD_ZEROS + BITS_WANTED);
  // short cycling only when fewer bits are asked for, else the full frame runs
  wire short_end = (BITS_WANTED < RESULT_BITS) && (rise_cnt == last_rise);
  wire frame_end = half_done && !sclk && (rise_cnt == 5'(sarsr_pkg::FRAME_CYCLES)
                   || short_end);
  // ************************************************************
  // clock divider, frame control and capture
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state <= SARSR_IDLE;
      cs_n <= 1'b1;
      sclk <= 1'b1;
      div <= 8'h00;
      rise_cnt <= 5'h00;
      gap <= 8'h00;
      shift <= '0;
      push <= 1'b0;
      d_m <= 1'b0;
      d_s <= 1'b0;
    end
    else if (i_ce)
    begin
      d_m <= link.dout;
      d_s <= d_m;
      push <= 1'b0;
      case (state)
        SARSR_IDLE:
        begin
          sclk <= 1'b1;
          div <= 8'h00;
          if (i_start && f_ready) // back-pressure holds off a new frame
          begin
            cs_n <= 1'b0; // clock high at select fall
            rise_cnt <= 5'h00;
            state <= SARSR_RUN;
          end
        end
        SARSR_RUN:
        begin
          div <= half_done ? 8'h00 : div + 8'h01;
          if (frame_end)
          begin
            cs_n <= 1'b1;
            push <= 1'b1;
            gap <= 8'h00;
            state <= SARSR_GAP;
          end
          else if (half_done)
          begin
            sclk <= !sclk;
            if (!sclk)
            begin
              rise_cnt <= rise_cnt + 5'h01;
              // sample data at rise: edges 3..16 hold msb..lsb
              if (rise_cnt >= 5'(sarsr_pkg::LEAD_ZEROS) && rise_cnt < 5'(sarsr_pkg::TRACK_EDGE))
                shift <= {shift[RESULT_BITS-2:0], d_s};
            end
          end
        end
        SARSR_GAP:
        begin
          sclk <= 1'b1;
          gap <= gap + 8'h01;
          if (gap == 8'(sarsr_pkg::TRACK_INTERVAL_CYC))
            state <= SARSR_IDLE;
        end
        default: state <= SARSR_IDLE;
      endcase
    end
  end
  assign link.cs_n = cs_n;
  assign link.sclk = sclk;
  // busy flag
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_busy <= 1'b0;
    else if (i_ce)
      o_busy <= (state != SARSR_IDLE);
  end
  // ************************************************************
  // result buffer
  // ************************************************************
  sarsr_fifo #(.WIDTH(RESULT_BITS), .DEPTH(sarsr_pkg::FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_valid(push),
    .o_ready(f_ready),
    .i_data(shift),
    .o_valid(f_valid),
    .i_ready(i_ready && !o_valid),
    .o_data(f_data)
  );
  // output stage register, keeps outputs straight from flops
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_valid <= 1'b0;
      o_data <= '0;
    end
    else if (i_ce)
    begin
      if (o_valid && i_ready)
        o_valid <= 1'b0;
      else if (!o_valid && f_valid && i_ready)
      begin
        o_valid <= 1'b1;
        o_data <= f_data;
      end
    end
  end
endmodule

/* tb/sarsr_props.sv */
// checker: timing relations on the link joining host and converter
// assumes: instantiated beside the joined interface, pins sampled raw
`timescale 1ns/1ps
module sarsr_props #(
  parameter int HALF_CYC = sarsr_pkg::SCLK_HALF_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dout,
  input wire logic dout_oe_n
);
  logic sclk_q;
  logic cs_q;
  logic [4:0] fall_cnt;
  logic [4:0] rise_cnt;
  logic [7:0] run;
  logic [7:0] gap;
  // edges seen at the pins, only inside a frame
  wire fall_now = sclk_q & ~sclk & ~cs_n;
  wire rise_now = ~sclk_q & sclk & ~cs_n;
  wire cs_fell = cs_q & ~cs_n;
  wire cs_rose = ~cs_q & cs_n;
  // ************************************************************
  // helper counters
  // ************************************************************
  // gap starts saturated so a frame right after reset is not flagged
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sclk_q <= 1'b1;
      cs_q <= 1'b1;
      fall_cnt <= 5'h00;
      rise_cnt <= 5'h00;
      run <= 8'h00;
      gap <= 8'hff;
    end
    else
    begin
      sclk_q <= sclk;
      cs_q <= cs_n;
      fall_cnt <= cs_fell ? 5'h00 : fall_cnt + {4'h0, fall_now};
      rise_cnt <= cs_fell ? 5'h00 : rise_cnt + {4'h0, rise_now};
      run <= (sclk != sclk_q) ? 8'h00 : run + {7'h00, run != 8'hff};
      gap <= cs_n ? gap + {7'h00, gap != 8'hff} : 8'h00;
    end
  end
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  oe_on_a: assert property (cs_fell |-> ##3 !dout_oe_n)
    else $error("data enable late after select fall");
  oe_idle_a: assert property (cs_n [*4] |-> dout_oe_n)
    else $error("data driven while select high");
  lead_zero_a: assert property (fall_now && fall_cnt < 5'h02 |-> ##3 !dout)
    else $error("leading bit not zero");
  dout_cause_a: assert property (!dout_oe_n && $changed(dout) |->
    $past(fall_now, 3) || $past(cs_fell, 3))
    else $error("data changed without a clock fall");
  track_hold_a: assert property (fall_now && fall_cnt >= 5'h10 |-> ##3 $stable(dout))
    else $error("data moved after sixteenth fall");
  frame_len_a: assert property (cs_rose |-> rise_cnt == 5'h12)
    else $error("frame not eighteen clock cycles");
  half_per_a: assert property ((rise_now || (fall_now && fall_cnt != 5'h00)) |->
    int'(run) == HALF_CYC - 1)
    else $error("link clock phase length wrong");
  gap_len_a: assert property (cs_fell |-> int'(gap) >= sarsr_pkg::TRACK_INTERVAL_CYC - 1)
    else $error("track gap too short");
  sclk_idle_a: assert property (cs_n && cs_q |-> sclk)
    else $error("link clock not idle high");
  cover property (cs_rose && rise_cnt == 5'h12);
  cover property (fall_now && fall_cnt == 5'h0f);
  cover property (cs_fell && gap != 8'hff);
endmodule

/* tb/testbench.sv */
// testbench: host and converter joined, plus a converter driven by hand
// assumes: package compiled first; checker watches the joined link only
`timescale 1ns/1ps
module testbench;
  localparam int HALF = 4;
  // host needs the full phase: its data path lags the pin by five cycles
  localparam int HOST_HALF = sarsr_pkg::SCLK_HALF_CYC;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_start = 1'b0;
  logic i_ready = 1'b0;
  logic [13:0] i_sample = 14'h0000;
  logic [13:0] sample_b = 14'h0000;
  logic [15:0] lfsr = 16'h3538;
  logic [13:0] corner [4] = '{14'h3fff, 14'h0000, 14'h2aaa, 14'h1555};
  logic [13:0] exp_q [$];
  logic o_busy;
  logic o_valid;
  logic [13:0] o_data;
  logic trk_b;
  logic conv_b;
  int bad_count = 0;
  int n_tests = 0;
  sarsr_if link_a();
  sarsr_if link_b();
  // ************************************************************
  // ends under test and checker
  // ************************************************************
  sarsr_host #(.HALF_CYC(HOST_HALF)) u_sarsr_host (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_ce(1'b1), .link(link_a), .i_start(i_start), .o_busy(o_busy), .o_valid(o_valid),
    .i_ready(i_ready), .o_data(o_data));
  sarsr_device u_sarsr_device (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(1'b1),
    .link(link_a), .i_sample(i_sample), .o_tracking(), .o_converting());
  // second converter faces the bench, which can break host habits
  sarsr_device u_sarsr_device_b (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(1'b1),
    .link(link_b), .i_sample(sample_b), .o_tracking(trk_b), .o_converting(conv_b));
  sarsr_props #(.HALF_CYC(HOST_HALF)) u_sarsr_props (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .cs_n(link_a.cs_n), .sclk(link_a.sclk), .dout(link_a.dout), .dout_oe_n(link_a.dout_oe_n));
  always #5 i_clk = ~i_clk;
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [15:0] next_rand(input logic [15:0] v);
    next_rand = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done;
    if (bad_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // sample held until the frame and its gap are over
  task automatic host_frame(input logic [13:0] value);
    @(posedge i_clk);
    i_sample <= value;
    i_start <= 1'b1;
    exp_q.push_back(value);
    @(posedge i_clk);
    i_start <= 1'b0;
    repeat (2) @(posedge i_clk);
    repeat (2000) if (o_busy === 1'b1) @(posedge i_clk);
  endtask
  // hand-made frame; bits read just before each rise
  task automatic frame_b(input int falls, input logic low_start);
    logic [17:0] got;
    logic [17:0] want;
    lfsr = next_rand(lfsr);
    @(posedge i_clk);
    sample_b <= lfsr[13:0];
    want = {2'b00, lfsr[13:0], lfsr[0], lfsr[0]};
    got = 18'h00000;
    link_b.sclk <= ~low_start;
    repeat (HALF) @(posedge i_clk);
    link_b.cs_n <= 1'b0;
    for (int i = 0; i < falls; i++)
    begin
      if (i > 0 || !low_start)
      begin
        repeat (HALF) @(posedge i_clk);
        link_b.sclk <= 1'b0;
      end
      repeat (HALF) @(posedge i_clk);
      got = {got[16:0], link_b.dout};
      link_b.sclk <= 1'b1;
      if (i == 1) check("oe_n", 18'h0, {17'h0, link_b.dout_oe_n});
      if (i == 8) check("conv", 18'h1, {17'h0, conv_b});
    end
    check("bits", want >> (18 - falls), got);
    repeat (HALF) @(posedge i_clk);
    link_b.cs_n <= 1'b1;
    repeat (5) @(posedge i_clk);
    check("oe_n", 18'h1, {17'h0, link_b.dout_oe_n});
    check("track", 18'h1, {17'h0, trk_b});
    repeat (90) @(posedge i_clk);
  endtask
  // ************************************************************
  // result monitor and watchdog
  // ************************************************************
  always @(posedge i_clk)
    if (o_valid === 1'b1 && i_ready === 1'b1)
    begin
      if (exp_q.size() > 0)
        check("word", {4'h0, exp_q.pop_front()}, {4'h0, o_data});
      else
        check("extra", 18'h0, 18'h1);
    end
  initial
  begin
    repeat (30000) @(posedge i_clk);
    bad_count++;
    test_done();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    link_b.cs_n = 1'b1;
    link_b.sclk = 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    i_ready <= 1'b1;
    foreach (corner[k]) host_frame(corner[k]);
    // consumer stalls until the buffer refuses a further frame
    i_ready <= 1'b0;
    for (int n = 0; n < 8; n++)
    begin
      lfsr = next_rand(lfsr);
      host_frame(lfsr[13:0]);
    end
    @(posedge i_clk);
    i_start <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_start <= 1'b0;
    check("busy", 18'h0, {17'h0, o_busy});
    repeat (120)
    begin
      @(posedge i_clk);
      lfsr = next_rand(lfsr);
      i_ready <= lfsr[0];
    end
    i_ready <= 1'b1;
    frame_b(18, 1'b0);
    frame_b(18, 1'b1);
    frame_b(5, 1'b0);
    frame_b(16, 1'b0);
    check("left", 18'h0, 18'(exp_q.size()));
    test_done();
  end
endmodule
